/* File: rtl/pvfu_top.sv */
// Process value function unit: math functions, cascade and APB registers
`timescale 1ns/1ps
`default_nettype none

module pvfu_top #(
  parameter int DW = pvfu_pkg::PVFU_DW
) (
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         RST_B_I,
  input  wire logic                         PSEL_I,
  input  wire logic                         PENABLE_I,
  input  wire logic                         PWRITE_I,
  input  wire logic [pvfu_pkg::PVFU_AW-1:0] PADDR_I,
  input  wire logic [31:0]                  PWDATA_I,
  output var  logic [31:0]                  PRDATA_O,
  output var  logic                         PREADY_O,
  output var  logic                         PSLVERR_O,
  input  wire logic                         CYCLE_TICK_I,
  input  wire logic signed [DW-1:0]         AIN1_I,
  input  wire logic                         AIN1_OK_I,
  input  wire logic signed [DW-1:0]         AIN2_I,
  input  wire logic                         SRC_E_LINKED_I,
  input  wire logic                         SRC_E_I,
  input  wire logic signed [DW-1:0]         LOOP1_POWER_I,
  input  wire logic signed [DW-1:0]         LOOP2_POWER_I,
  input  wire logic                         LOOP1_MODE_SET_I,
  input  wire logic [1:0]                   LOOP1_MODE_I,
  input  wire logic                         LOOP2_MODE_SET_I,
  input  wire logic [1:0]                   LOOP2_MODE_I,
  output var  logic signed [DW-1:0]         PV_O,
  output var  logic signed [DW-1:0]         LOOP1_PV_O,
  output var  logic signed [DW-1:0]         LOOP1_TARGET_O,
  output var  logic signed [DW-1:0]         LOOP2_PV_O,
  output var  logic signed [DW-1:0]         LOOP2_TARGET_O,
  output var  logic [DW-1:0]                HEAT1_O,
  output var  logic [DW-1:0]                COOL1_O,
  output var  logic [DW-1:0]                HEAT2_O,
  output var  logic [DW-1:0]                COOL2_O,
  output var  logic                         CASCADE_EN_O,
  output var  logic [1:0]                   LOOP1_MODE_O,
  output var  logic [1:0]                   LOOP2_MODE_O,
  output var  logic                         UPDATE_O
);
  import pvfu_pkg::*;

  localparam logic signed [31:0] VMAX = 32'sd2 ** (DW - 1) - 32'sd1;
  localparam logic signed [31:0] VMIN = -(32'sd2 ** (DW - 1));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] clamp(input logic signed [31:0] x,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    clamp = (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction

  function automatic logic signed [DW-1:0] sat(input logic signed [31:0] x);
    logic signed [31:0] c;
    c   = clamp(x, VMIN, VMAX);
    sat = c[DW-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pvfu_func_t           func_q;
  logic signed [DW-1:0] tgt1_q, tgt2_q, scl_lo_q, scl_hi_q;
  logic signed [DW-1:0] rng_lo_q, rng_hi_q, dev_lo_q, dev_hi_q;
  logic                 pready_q, pslverr_q, div_err_q;
  logic [31:0]          prdata_q;
  pvfu_state_t          state_q;
  logic signed [DW-1:0] s_a, s_b, s_p1, s_p2;
  logic                 s_a_ok;

  // ----------------------------------------------------------------
  // APB decode: one wait state, answer registered
  // ----------------------------------------------------------------
  logic        acc_first;
  logic        wr_done;
  logic        hit;
  logic [31:0] rd_word;
  logic [7:0]  adr;
  logic [3:0]  status;

  assign adr       = PADDR_I;
  assign acc_first = PSEL_I & PENABLE_I & ~pready_q;
  assign wr_done   = PSEL_I & PENABLE_I & pready_q & PWRITE_I & ~pslverr_q;
  assign hit       = (adr[1:0] == 2'b00) && (adr <= OFS_PV)
                     && !(PWRITE_I && (adr == OFS_STATUS || adr == OFS_PV));
  assign status    = {div_err_q, state_q == ST_IDLE, HEAT2_O != '0 || COOL2_O != '0,
                      CASCADE_EN_O};
  assign rd_word   = (adr == OFS_CTRL)     ? {29'h0, func_q}                  :
                     (adr == OFS_TARGET1)  ? 32'(tgt1_q)                      :
                     (adr == OFS_TARGET2)  ? 32'(tgt2_q)                      :
                     (adr == OFS_SCALE_LO) ? 32'(scl_lo_q)                    :
                     (adr == OFS_SCALE_HI) ? 32'(scl_hi_q)                    :
                     (adr == OFS_RANGE_LO) ? 32'(rng_lo_q)                    :
                     (adr == OFS_RANGE_HI) ? 32'(rng_hi_q)                    :
                     (adr == OFS_DEV_LO)   ? 32'(dev_lo_q)                    :
                     (adr == OFS_DEV_HI)   ? 32'(dev_hi_q)                    :
                     (adr == OFS_MODE)     ? {28'h0, LOOP2_MODE_O, LOOP1_MODE_O} :
                     (adr == OFS_STATUS)   ? {28'h0, status}                  :
                     (adr == OFS_PV)       ? 32'(PV_O)                        : 32'h0;

  // Bus handshake and read data
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & ~hit;
      prdata_q  <= (acc_first && !PWRITE_I && hit) ? rd_word : 32'h0;
    end
  end

  assign PREADY_O  = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O  = prdata_q;

  // Settings written by software
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      func_q   <= FN_OFF;
      tgt1_q   <= '0;
      tgt2_q   <= '0;
      scl_lo_q <= RST_SCALE_LO;
      scl_hi_q <= RST_SCALE_HI;
      rng_lo_q <= RST_RANGE_LO;
      rng_hi_q <= RST_RANGE_HI;
      dev_lo_q <= RST_DEV;
      dev_hi_q <= RST_DEV;
    end
    else if (wr_done)
    begin
      if (adr == OFS_CTRL)     func_q   <= pvfu_func_t'(PWDATA_I[2:0]);
      if (adr == OFS_TARGET1)  tgt1_q   <= PWDATA_I[DW-1:0];
      if (adr == OFS_TARGET2)  tgt2_q   <= PWDATA_I[DW-1:0];
      if (adr == OFS_SCALE_LO) scl_lo_q <= PWDATA_I[DW-1:0];
      if (adr == OFS_SCALE_HI) scl_hi_q <= PWDATA_I[DW-1:0];
      if (adr == OFS_RANGE_LO) rng_lo_q <= PWDATA_I[DW-1:0];
      if (adr == OFS_RANGE_HI) rng_hi_q <= PWDATA_I[DW-1:0];
      if (adr == OFS_DEV_LO)   dev_lo_q <= PWDATA_I[DW-1:0];
      if (adr == OFS_DEV_HI)   dev_hi_q <= PWDATA_I[DW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Cascade enable and linked loop modes
  // ----------------------------------------------------------------
  logic       casc_sel;
  logic       casc_en;
  logic       mode_wr;
  logic [1:0] mode1_d, mode2_d;

  assign casc_sel = (func_q == FN_PROC) || (func_q == FN_DEV);
  assign casc_en  = casc_sel && (!SRC_E_LINKED_I || !SRC_E_I);
  assign mode_wr  = wr_done && (adr == OFS_MODE);
  // Bus write beats loop one request, which beats loop two
  assign mode1_d  = mode_wr          ? PWDATA_I[1:0] :
                    LOOP1_MODE_SET_I ? LOOP1_MODE_I  :
                    (LOOP2_MODE_SET_I && casc_en) ? LOOP2_MODE_I : LOOP1_MODE_O;
  assign mode2_d  = mode_wr          ? (casc_en ? PWDATA_I[1:0] : PWDATA_I[3:2]) :
                    (LOOP1_MODE_SET_I && casc_en) ? LOOP1_MODE_I :
                    LOOP2_MODE_SET_I ? LOOP2_MODE_I : LOOP2_MODE_O;

  // Modes and cascade flag follow settings every clock
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      LOOP1_MODE_O <= 2'b00;
      LOOP2_MODE_O <= 2'b00;
      CASCADE_EN_O <= 1'b0;
    end
    else
    begin
      LOOP1_MODE_O <= mode1_d;
      LOOP2_MODE_O <= mode2_d;
      CASCADE_EN_O <= casc_en;
    end
  end

  // ----------------------------------------------------------------
  // Control-cycle sequencer: sample, root, publish
  // ----------------------------------------------------------------
  logic        root_done;
  logic [15:0] root_val;
  logic [31:0] root_op;
  logic        go;

  assign go = (state_q == ST_IDLE) && CYCLE_TICK_I;
  // Ticks that land mid-computation are dropped; a cycle is 18 clocks from tick to update
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      state_q <= ST_IDLE;
      s_a     <= '0;
      s_b     <= '0;
      s_p1    <= '0;
      s_p2    <= '0;
      s_a_ok  <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (go)
          begin
            state_q <= ST_ROOT;
            s_a     <= AIN1_I;
            s_b     <= AIN2_I;
            s_p1    <= LOOP1_POWER_I;
            s_p2    <= LOOP2_POWER_I;
            s_a_ok  <= AIN1_OK_I;
          end
        end
        ST_ROOT: if (root_done) state_q <= ST_OUT;
        ST_OUT:  state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Root starts on the sampling edge, so it must take the live reading
  assign root_op = (AIN1_I < 0) ? 32'h0 : 32'(32'(AIN1_I) * SQRT_GAIN);

  pvfu_sqrt #(
    .W (32)
  ) u_sqrt (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .start_i (state_q == ST_IDLE && go),
    .op_i    (root_op),
    .done_o  (root_done),
    .root_o  (root_val)
  );

  // ----------------------------------------------------------------
  // Math functions on the sampled inputs
  // ----------------------------------------------------------------
  logic signed [31:0] a32, b32, p1_32, p2_32, t1_32, diff32, ratio32, rh32;
  logic signed [31:0] proc32, devoff32, dev32, remote32, drive32, span32;
  logic               b_zero, dry_ok;
  logic signed [DW-1:0] pv_d, remote_d;

  assign a32    = 32'(s_a);
  assign b32    = 32'(s_b);
  assign p1_32  = clamp(32'(s_p1), -POWER_FULL, POWER_FULL);
  assign p2_32  = clamp(32'(s_p2), -POWER_FULL, POWER_FULL);
  assign t1_32  = 32'(tgt1_q);
  assign diff32 = a32 - b32;
  assign b_zero = (s_b == '0);
  // Division by zero saturates toward the sign of source A
  assign ratio32 = b_zero ? ((a32 < 0) ? VMIN : VMAX)
                          : (a32 * RATIO_ONE) / b32;
  // Straight-line humidity: full at no depression, falls per tenth
  assign rh32   = clamp(RH_FULL - diff32 * RH_LOSS, 0, RH_FULL);
  assign dry_ok = (a32 >= DRY_MIN) && (a32 <= DRY_MAX);

  // Process scale: -100% lands on scale low, +100% on scale high
  assign span32 = 32'(scl_hi_q) - 32'(scl_lo_q);
  assign proc32 = clamp(32'(scl_lo_q) + ((p1_32 + POWER_FULL) * span32) / (2 * POWER_FULL),
                        32'(rng_lo_q), 32'(rng_hi_q));
  // Deviation scale: each side has its own limit
  assign devoff32 = (p1_32 >= 0) ? (p1_32 * 32'(dev_hi_q)) / POWER_FULL
                                 : (p1_32 * 32'(dev_lo_q)) / POWER_FULL;
  assign dev32    = !s_a_ok ? t1_32
                  : clamp(t1_32 + devoff32, t1_32 - 32'(dev_lo_q),
                          t1_32 + 32'(dev_hi_q));
  assign remote32 = (func_q == FN_PROC) ? proc32 : dev32;
  assign remote_d = sat(remote32);

  // Function output selection
  assign pv_d = (casc_sel && !casc_en)   ? tgt1_q                    :
                casc_sel                 ? remote_d                  :
                (func_q == FN_BACKUP)    ? (s_a_ok ? s_a : s_b)      :
                (func_q == FN_ROOT)      ? sat(32'(root_val))        :
                (func_q == FN_RATIO)     ? sat(ratio32)              :
                (func_q == FN_DIFF)      ? sat(diff32)               :
                (func_q == FN_WETDRY)    ? sat(rh32)                 : s_a;

  // Cascade takes power from the inner loop only, sensor state aside
  assign drive32 = casc_en ? p2_32 : p1_32;

  // ----------------------------------------------------------------
  // Published results, held for a whole control cycle
  // ----------------------------------------------------------------
  logic loop1_uses_pv;
  logic hum_on;

  assign loop1_uses_pv = (func_q == FN_BACKUP) || (func_q == FN_ROOT) ||
                         (func_q == FN_RATIO) || (func_q == FN_DIFF);
  assign hum_on        = (func_q != FN_WETDRY) || dry_ok;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      PV_O           <= '0;
      LOOP1_PV_O     <= '0;
      LOOP1_TARGET_O <= '0;
      LOOP2_PV_O     <= '0;
      LOOP2_TARGET_O <= '0;
      HEAT1_O        <= '0;
      COOL1_O        <= '0;
      HEAT2_O        <= '0;
      COOL2_O        <= '0;
      UPDATE_O       <= 1'b0;
      div_err_q      <= 1'b0;
    end
    else
    begin
      UPDATE_O <= (state_q == ST_OUT);
      if (state_q == ST_OUT)
      begin
        PV_O           <= pv_d;
        LOOP1_PV_O     <= loop1_uses_pv ? pv_d : s_a;
        LOOP1_TARGET_O <= tgt1_q;
        LOOP2_PV_O     <= s_b;
        LOOP2_TARGET_O <= casc_en ? remote_d : tgt2_q;
        HEAT1_O        <= (drive32 > 0) ? drive32[DW-1:0] : '0;
        COOL1_O        <= (drive32 < 0) ? DW'(-drive32) : '0;
        HEAT2_O        <= (hum_on && p2_32 > 0) ? p2_32[DW-1:0] : '0;
        COOL2_O        <= (hum_on && p2_32 < 0) ? DW'(-p2_32) : '0;
        div_err_q      <= (func_q == FN_RATIO) && b_zero;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pvfu_pkg.sv */
// Constants, register map and types of the process value function unit
//
// Behaviour
// - Single-loop operation gives loop one input one as its value and its first target.
// - Backup function outputs source A while input one is valid, else source B.
// - Root function outputs the square root of source A as loop one's value.
// - Ratio function outputs source A as a ratio to source B, in thousandths.
// - Differential function outputs source A minus source B.
// - Cascade is on when process or deviation scale is chosen and source E is unlinked or false.
// - Cascade chosen but disabled by a true source E makes the output equal loop one's target.
// - Process scale maps outer power from full cool to full heat onto scale limits, within range.
// - Deviation scale keeps the remote target within the deviation limits of loop one's target.
// - In cascade the outer loop output is the inner loop target, loop one outer, loop two inner.
// - In cascade a mode change of either loop is applied to both loops.
// - Inner loop power runs from -100% to +100%; positive drives heat, negative drives cool.
// - In cascade heat and cool drive come only from loop two.
// - In deviation cascade a failed outer sensor leaves the inner loop driving its outputs.
// - Wet/dry-bulb outputs humidity from the temperature difference; loop two holds input two.
// - Wet/dry-bulb disables both humidity outputs when dry bulb is below 0 C or above 100 C.

package pvfu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PVFU_DW = 16;
  localparam int PVFU_AW = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TARGET1  = 8'h04;
  localparam logic [7:0] OFS_TARGET2  = 8'h08;
  localparam logic [7:0] OFS_SCALE_LO = 8'h0C;
  localparam logic [7:0] OFS_SCALE_HI = 8'h10;
  localparam logic [7:0] OFS_RANGE_LO = 8'h14;
  localparam logic [7:0] OFS_RANGE_HI = 8'h18;
  localparam logic [7:0] OFS_DEV_LO   = 8'h1C;
  localparam logic [7:0] OFS_DEV_HI   = 8'h20;
  localparam logic [7:0] OFS_MODE     = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;
  localparam logic [7:0] OFS_PV       = 8'h2C;

  // ----------------------------------------------------------------
  // Reset values (tenths of a unit)
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SCALE_LO = 16'h0000;
  localparam logic [15:0] RST_SCALE_HI = 16'h03E8;
  localparam logic [15:0] RST_RANGE_LO = 16'h8000;
  localparam logic [15:0] RST_RANGE_HI = 16'h7FFF;
  localparam logic [15:0] RST_DEV      = 16'h00FA;

  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam int POWER_FULL = 1000;   // 100.0 % in tenths
  localparam int RATIO_ONE  = 1000;   // ratio 1.000
  localparam int SQRT_GAIN  = 100;    // keeps root in tenths
  localparam int RH_FULL    = 1000;   // 100.0 %RH
  localparam int RH_LOSS    = 6;      // tenths %RH lost per tenth degree
  localparam int DRY_MIN    = 0;      // 0.0 C
  localparam int DRY_MAX    = 1000;   // 100.0 C

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_OFF    = 3'h0,
    FN_BACKUP = 3'h1,
    FN_ROOT   = 3'h2,
    FN_RATIO  = 3'h3,
    FN_DIFF   = 3'h4,
    FN_PROC   = 3'h5,
    FN_DEV    = 3'h6,
    FN_WETDRY = 3'h7
  } pvfu_func_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ROOT = 3'b010,
    ST_OUT  = 3'b100
  } pvfu_state_t;

endpackage

/* File: rtl/pvfu_sqrt.sv */
// Iterative integer square root, one result bit per clock
`timescale 1ns/1ps
`default_nettype none

module pvfu_sqrt #(
  parameter int W = 32
) (
  input  wire logic           clk_i,
  input  wire logic           rst_b_i,
  input  wire logic           start_i,
  input  wire logic [W-1:0]   op_i,
  output var  logic           done_o,
  output var  logic [W/2-1:0] root_o
);

  logic [W-1:0]   rem_q;
  logic [W-1:0]   bit_q;
  logic [W-1:0]   res_q;
  logic           busy_q;
  logic [W-1:0]   trial;
  logic           fits;

  // ----------------------------------------------------------------
  // Restoring digit recurrence
  // ----------------------------------------------------------------
  assign trial  = res_q + bit_q;
  assign fits   = rem_q >= trial;
  assign root_o = res_q[W/2-1:0];

  // Bit walks down two places per step; done when it leaves the word
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rem_q  <= '0;
      bit_q  <= '0;
      res_q  <= '0;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end
    else if (start_i)
    begin
      rem_q  <= op_i;
      bit_q  <= {2'b01, {(W-2){1'b0}}};
      res_q  <= '0;
      busy_q <= 1'b1;
      done_o <= 1'b0;
    end
    else if (busy_q)
    begin
      rem_q  <= fits ? rem_q - trial : rem_q;
      res_q  <= fits ? (res_q >> 1) + bit_q : res_q >> 1;
      bit_q  <= bit_q >> 2;
      busy_q <= bit_q[1:0] == 2'b00;
      done_o <= bit_q[1:0] != 2'b00;
    end
    else
    begin
      done_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: tb/pvfu_far_end.sv */
// Sensor readings and loop powers seen by the function unit
`timescale 1ns/1ps
`default_nettype none

module pvfu_far_end (
  input  wire logic               clk_i,
  input  wire logic               load_i,
  input  wire logic [63:0]        val_i,
  input  wire logic               ok_i,
  output var  logic signed [15:0] ain1_o,
  output var  logic signed [15:0] ain2_o,
  output var  logic signed [15:0] pow1_o,
  output var  logic signed [15:0] pow2_o,
  output var  logic               ok_o
);
  // ----
  // Readings
  // ----
  logic [64:0] hold_q = '0;
  // A failed sensor shows a scrambled reading, never the last good one
  always @(posedge clk_i)
    if (load_i)
      hold_q <= {(ok_i ? val_i[63:48] : ~val_i[63:48]), val_i[47:0], ok_i};
  assign {ain1_o, ain2_o, pow1_o, pow2_o, ok_o} = hold_q;
endmodule
`default_nettype wire

/* File: tb/pvfu_assertions.sv */
// Port assertions for the process value function unit
`timescale 1ns/1ps
`default_nettype none

module pvfu_checker #(
  parameter int DW = 16
) (
  input wire logic CORE_CLK_I, RST_B_I, PSEL_I, PENABLE_I, PREADY_O, PSLVERR_O,
  input wire logic [pvfu_pkg::PVFU_AW-1:0] PADDR_I,
  input wire logic CYCLE_TICK_I, UPDATE_O, CASCADE_EN_O, SRC_E_LINKED_I, SRC_E_I,
  input wire logic LOOP1_MODE_SET_I, LOOP2_MODE_SET_I,
  input wire logic [1:0] LOOP1_MODE_I, LOOP2_MODE_O,
  input wire logic signed [DW-1:0] LOOP2_POWER_I, PV_O,
  input wire logic [DW-1:0] HEAT1_O, COOL1_O
);
  import pvfu_pkg::*;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  // ----
  // Sequences
  // ----
  sequence s_one_wait;
    !PREADY_O ##1 PREADY_O;
  endsequence
  sequence s_refresh;
    ##[17:20] UPDATE_O;
  endsequence
  // ----
  // Checks
  // ----
  AST_APB_WAIT: assert property ($rose(PENABLE_I) && PSEL_I |-> s_one_wait)
    else $error("ready not after one wait");
  AST_BAD_ADDR: assert property (PREADY_O && (PADDR_I > OFS_PV || PADDR_I[1:0] != 2'h0)
    |-> PSLVERR_O) else $error("bad address accepted");
  AST_CASC_OFF: assert property (
    CASCADE_EN_O |-> !($past(SRC_E_LINKED_I) && $past(SRC_E_I))) else $error("cascade on");
  AST_HC_EXCL: assert property (!(HEAT1_O != '0 && COOL1_O != '0))
    else $error("heat and cool together");
  AST_CASC_DRIVE: assert property (UPDATE_O && CASCADE_EN_O |->
    HEAT1_O == DW'(LOOP2_POWER_I > 0 ? LOOP2_POWER_I : 0) &&
    COOL1_O == DW'(LOOP2_POWER_I < 0 ? -LOOP2_POWER_I : 0)) else $error("drive not loop two");
  AST_MODE_LINK: assert property (
    CASCADE_EN_O && LOOP1_MODE_SET_I && !LOOP2_MODE_SET_I |=> LOOP2_MODE_O == $past(LOOP1_MODE_I))
    else $error("modes not linked");
  AST_TICK: assert property (CYCLE_TICK_I |-> s_refresh)
    else $error("no refresh after tick");
  AST_UPD_PULSE: assert property (UPDATE_O |=> !UPDATE_O)
    else $error("refresh longer than a cycle");
  AST_PV_HOLD: assert property ($changed(PV_O) |-> UPDATE_O)
    else $error("value moved between refreshes");
endmodule

bind pvfu_top pvfu_checker #(.DW(DW)) i_pvfu_checker (.CORE_CLK_I, .RST_B_I, .PSEL_I,
  .PENABLE_I, .PREADY_O, .PSLVERR_O, .PADDR_I, .CYCLE_TICK_I, .UPDATE_O, .CASCADE_EN_O,
  .SRC_E_LINKED_I, .SRC_E_I, .LOOP1_MODE_SET_I, .LOOP2_MODE_SET_I, .LOOP1_MODE_I,
  .LOOP2_MODE_O, .LOOP2_POWER_I, .PV_O, .HEAT1_O, .COOL1_O);
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the process value function unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got %0h exp %0h", $time, g, e); end end

module tb;
  import pvfu_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, tick = 0, load = 0, ok = 1;
  logic el = 0, ev = 0, m1s = 0, m2s = 0, okd, pready, pslverr, casc, upd, okr, cas;
  logic [1:0] m1 = 0, m2 = 0, m1o, m2o;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rr;
  logic [63:0] val = 0;
  logic signed [15:0] a1, a2, p1, p2, pv, l1t, l2t, l1p, l2p;
  logic [15:0] h1, c1, h2, c2;
  logic [7:0] ra [11] = '{OFS_TARGET2, OFS_SCALE_LO, OFS_SCALE_HI, OFS_RANGE_LO,
    OFS_RANGE_HI, OFS_DEV_LO, OFS_DEV_HI, 8'h30, 8'h05, OFS_PV, OFS_STATUS};
  logic [31:0] rv [7] = '{32'h123, 32'h0, 32'h3E8, 32'hFFFF8000, 32'h7FFF, 32'hFA, 32'hFA};
  int err_total = 0, checks = 0, f, a, b, q1, q2, t1, hp;

  always #5 clk = ~clk;

  pvfu_top i_pvfu_top (.CORE_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CYCLE_TICK_I(tick), .AIN1_I(a1), .AIN1_OK_I(okd), .AIN2_I(a2),
    .SRC_E_LINKED_I(el), .SRC_E_I(ev), .LOOP1_POWER_I(p1), .LOOP2_POWER_I(p2),
    .LOOP1_MODE_SET_I(m1s), .LOOP1_MODE_I(m1), .LOOP2_MODE_SET_I(m2s), .LOOP2_MODE_I(m2),
    .PV_O(pv), .LOOP1_PV_O(l1p), .LOOP1_TARGET_O(l1t), .LOOP2_PV_O(l2p), .LOOP2_TARGET_O(l2t),
    .HEAT1_O(h1), .COOL1_O(c1), .HEAT2_O(h2), .COOL2_O(c2), .CASCADE_EN_O(casc),
    .LOOP1_MODE_O(m1o), .LOOP2_MODE_O(m2o), .UPDATE_O(upd));
  pvfu_far_end i_pvfu_far_end (.clk_i(clk), .load_i(load), .val_i(val), .ok_i(ok),
    .ain1_o(a1), .ain2_o(a2), .pow1_o(p1), .pow2_o(p2), .ok_o(okd));

  // ----
  // Tasks and reference model
  // ----
  // One APB transfer; waits for ready rather than assuming the wait count
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic xe);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rr = prdata;
    `CHK({pready, pslverr}, {1'b1, xe})
    {psel, pen} <= 2'b00;
  endtask

  task automatic mode(input logic s2, input logic [1:0] v, input logic [3:0] x);
    @(posedge clk);
    {m1s, m2s, m1, m2} <= {!s2, s2, v, v};
    @(posedge clk);
    {m1s, m2s} <= 2'b00;
    @(posedge clk);
    `CHK({m1o, m2o}, x)
  endtask

  function automatic int pv_model(int fn, int x, int y, int t, logic okv);
    int r = 0;
    case (fn)
      1: r = okv ? x : y;
      2: while (x > 0 && (r + 1) * (r + 1) <= x * 100) r++;
      3: r = x * 1000 / y;
      4: r = x - y;
      7: r = 1000 - 6 * (x - y);
      default: r = t;
    endcase
    return (fn == 7) ? ((r < 0) ? 0 : (r > 1000) ? 1000 : r) : r;
  endfunction

  task automatic report_and_stop;
    $display("Checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----
  // Sequence
  // ----
  initial
  begin
    void'($urandom(32'h7ADAD91B));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    acc(1'b1, OFS_TARGET2, 32'h123, 1'b0);
    // Written target two and reset values, then refused places: unmapped, unaligned, read-only
    for (int i = 0; i < 11; i++)
    begin
      acc(i > 8, ra[i], 32'h0, i > 6);
      if (i < 7) `CHK(rr, rv[i])
    end
    for (int i = 0; i < 14; i++)
    begin
      f = 1 + i % 7;
      a = int'($urandom % 1600) - 500;
      b = int'($urandom % 500) + 100;
      q1 = 4 * (int'($urandom % 501) - 250);
      q2 = 4 * (int'($urandom % 501) - 250);
      t1 = int'($urandom % 1000);
      okr = (f == 1 || f == 6) ? 1'($urandom) : 1'b1;
      acc(1'b1, OFS_CTRL, 32'(f), 1'b0);
      acc(1'b1, OFS_TARGET1, 32'(t1), 1'b0);
      {load, val, ok, el, ev} <= {1'b1, 16'(a), 16'(b), 16'(q1), 16'(q2), okr, 1'($urandom), i > 6};
      @(posedge clk);
      {load, tick} <= 2'b01;
      @(posedge clk);
      tick <= 1'b0;
      repeat (25)
      begin
        @(posedge clk);
        if (upd === 1'b1) break;
      end
      cas = (f == 5 || f == 6) && !(el && ev);
      hp = cas ? q2 : q1;
      `CHK({upd, casc, l1t}, {1'b1, cas, 16'(t1)})
      `CHK({h1, c1}, {16'(hp > 0 ? hp : 0), 16'(hp < 0 ? -hp : 0)})
      if (!cas) `CHK(pv, 16'(pv_model(f, a, b, t1, okr)))
      else `CHK(l2t, 16'(f == 5 ? (q1 + 1000) / 2 : okr ? t1 + q1 / 4 : t1))
      `CHK(l1p, 16'(f < 5 ? pv_model(f, a, b, t1, okr) : okr ? a : ~a))
      `CHK(l2p, 16'(b))
      hp = (a < 0 || a > 1000) ? 0 : q2;
      if (f == 7) `CHK({h2, c2}, {16'(hp > 0 ? hp : 0), 16'(hp < 0 ? -hp : 0)})
    end
    acc(1'b1, OFS_CTRL, 32'h5, 1'b0);
    ev <= 1'b0;
    mode(1'b0, 2'h1, 4'h5);
    mode(1'b1, 2'h2, 4'hA);
    acc(1'b1, OFS_CTRL, 32'h1, 1'b0);
    mode(1'b0, 2'h3, 4'hE);
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
